/* File: logic/apf_pkg.sv */
package apf_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_PS = 25000;        // 40 MHz system clock
  localparam int OC_STOP_MIN_US = 200;         // Earliest overcurrent stop
  localparam int OC_STOP_MAX_US = 390;         // Latest overcurrent stop
  // Least time rounds up to whole cycles
  localparam int OC_STOP_CYCLES =
    (OC_STOP_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PWM_PERIOD_CYCLES = 100;      // Default 400 kHz switching
  localparam int NUM_CH = 4;                   // Amplifier channels

  // Register offsets
  localparam logic [7:0] FAULT_STATUS_ADDR = 8'h02;
  localparam logic [7:0] SUPPLY_STATUS_ADDR = 8'h03;
  localparam logic [7:0] THERMAL_WARNING_STATUS_ADDR = 8'h04;
  localparam logic [7:0] DC_CONTROL_ADDR = 8'h05;
  localparam logic [7:0] WARN_PIN_FUNCTION_SELECT_ADDR = 8'h0a;
  localparam logic [7:0] CHANNEL_PLAY_CONTROL_ADDR = 8'h0c;
  localparam logic [7:0] TWEETER_CONTROL_ADDR = 8'h0d;

  // Field positions
  localparam int THERM_WARN_LSB = 5;           // Warning levels in 7:5
  localparam int SUP_LOW_PWR = 0;              // Power-stage undervoltage
  localparam int SUP_LOW_ANA = 1;              // Analog undervoltage
  localparam int SUP_LOW_PUMP = 2;             // Charge-pump undervoltage
  localparam int SUP_HIGH = 3;                 // Power-stage overvoltage
  localparam int SUP_TSD = 4;                  // Thermal shutdown
  localparam int DC_SD_EN_BIT = 0;             // Dc shutdown enable
  localparam int DC_TIME_LSB = 1;              // Dc duration in 7:1

  // Reset values
  localparam logic [7:0] PLAY_RESET = 8'h00;
  localparam logic [7:0] DC_CONTROL_RESET = 8'h20;
  localparam logic [7:0] TWEETER_RESET = 8'h00;

  // Shared pin functions
  typedef enum logic [1:0] {
    APF_CW_CLIP,
    APF_CW_WARN,
    APF_CW_BOTH,
    APF_CW_TWEETER
  } apf_cw_mode_e;
  localparam apf_cw_mode_e CW_MODE_RESET = APF_CW_WARN;
endpackage : apf_pkg

/* File: logic/apf_monitor.sv */
`timescale 1ns/1ps
module apf_monitor #(
  parameter int OC_STOP_DELAY = apf_pkg::OC_STOP_CYCLES,
  parameter int PWM_DIV = apf_pkg::PWM_PERIOD_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic [apf_pkg::NUM_CH-1:0] avg_limit_i,
  input wire logic [apf_pkg::NUM_CH-1:0] peak_limit_i,
  input wire logic [apf_pkg::NUM_CH-1:0] severe_oc_i,
  input wire logic [apf_pkg::NUM_CH-1:0] dc_offset_i,
  input wire logic [apf_pkg::NUM_CH-1:0] full_duty_i,
  input wire logic [apf_pkg::NUM_CH-1:0] tweeter_current_i,
  input wire logic [2:0] overtemp_warning_i,
  input wire logic thermal_shutdown_i,
  input wire logic low_power_stage_i,
  input wire logic low_analog_i,
  input wire logic low_charge_pump_i,
  input wire logic high_supply_detect_i,
  output logic [7:0] reg_rdata_o,
  output logic port_hiz_o,
  output logic [apf_pkg::NUM_CH-1:0] ch_hiz_o,
  output logic [apf_pkg::NUM_CH-1:0] pulse_cut_o,
  output logic [1:0] gain_fold_o,
  output logic fault_pin_out_o,
  output logic fault_pin_oe_n_o,
  output logic clip_warn_pin_out_o,
  output logic clip_warn_pin_oe_n_o
);
  import apf_pkg::*;

  localparam int OCW = $clog2(OC_STOP_DELAY + 1);
  localparam int PWW = $clog2(PWM_DIV + 1);
  localparam logic [OCW-1:0] OC_LAST = OCW'(OC_STOP_DELAY - 1);
  localparam logic [PWW-1:0] PW_LAST = PWW'(PWM_DIV - 1);

  // Configuration written by the host
  logic [NUM_CH-1:0] play;             // Channel play requests
  logic [NUM_CH-1:0] tweeter_en;       // Channels in tweeter mode
  logic [7:0] dc_control;              // Shutdown enable and duration
  apf_cw_mode_e cw_mode;               // Shared pin function
  // Recorded faults
  logic [NUM_CH-1:0] oc_fault;         // Overcurrent stops
  logic [NUM_CH-1:0] dc_fault;         // Dc detect triggers
  logic [4:0] supply_fault;            // Supply and thermal records
  // Timing
  logic [PWW-1:0] pwm_div;             // Switching period divider
  logic pwm_tick;                      // One pulse per PWM period
  logic [PWW-1:0] tw_hold;             // Tweeter low-pulse stretch
  logic tw_low;                        // Tweeter report active

  logic wr_fault, wr_supply;           // Write-one-to-clear strobes
  logic cfg_clear;                     // Configuration lost on reset
  logic dc_sd_en;
  logic [6:0] dc_time;
  logic [NUM_CH-1:0] dc_stop;          // Dc triggers that stop a channel
  logic [4:0] supply_now;              // Live supply conditions
  logic any_fault;
  logic tw_hit;

  assign wr_fault = reg_wr_i && reg_addr_i == FAULT_STATUS_ADDR;
  assign wr_supply = reg_wr_i && reg_addr_i == SUPPLY_STATUS_ADDR;
  assign cfg_clear = por_i;
  assign dc_sd_en = dc_control[DC_SD_EN_BIT];
  assign dc_time = dc_control[7:DC_TIME_LSB];
  assign dc_stop = dc_fault & {NUM_CH{dc_sd_en}};
  assign supply_now = {thermal_shutdown_i, high_supply_detect_i,
                       low_charge_pump_i, low_analog_i, low_power_stage_i};

  // Decode of the register write target
  function automatic logic wr_hit(input logic [7:0] addr,
                                  input logic [7:0] target);
    wr_hit = addr == target;
  endfunction : wr_hit

  // Host configuration; wiped again by power-on reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      play <= PLAY_RESET[NUM_CH-1:0];
      tweeter_en <= TWEETER_RESET[NUM_CH-1:0];
      dc_control <= DC_CONTROL_RESET;
      cw_mode <= CW_MODE_RESET;
    end else if (cfg_clear) begin
      play <= PLAY_RESET[NUM_CH-1:0];
      tweeter_en <= TWEETER_RESET[NUM_CH-1:0];
      dc_control <= DC_CONTROL_RESET;
      cw_mode <= CW_MODE_RESET;
    end else if (reg_wr_i) begin
      // Play bits enable channels; a stopped channel restarts when its fault record is cleared
      if (wr_hit(reg_addr_i, CHANNEL_PLAY_CONTROL_ADDR)) begin
        play <= reg_wdata_i[NUM_CH-1:0];
      end
      if (wr_hit(reg_addr_i, TWEETER_CONTROL_ADDR)) begin
        tweeter_en <= reg_wdata_i[NUM_CH-1:0];
      end
      if (wr_hit(reg_addr_i, DC_CONTROL_ADDR)) begin
        dc_control <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, WARN_PIN_FUNCTION_SELECT_ADDR)) begin
        cw_mode <= apf_cw_mode_e'(reg_wdata_i[1:0]);
      end
    end
  end

  // PWM period divider gives the slow timing enable
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwm_div <= '0;
      pwm_tick <= 1'b0;
    end else begin
      pwm_tick <= pwm_div == PW_LAST;
      pwm_div <= (pwm_div == PW_LAST) ? '0 : pwm_div + 1'b1;
    end
  end

  // Per-channel overcurrent and dc detectors
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [OCW-1:0] oc_count;        // Time the short has persisted
      logic [6:0] dc_count;            // PWM periods of dc offset

      // Short must last the least stop time; a brief peak only limits
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          oc_count <= '0;
        end else if (!severe_oc_i[ch] || oc_fault[ch]) begin
          oc_count <= '0;
        end else if (oc_count != OC_LAST) begin
          oc_count <= oc_count + 1'b1;
        end
      end

      // Stop record; a new short beats a clear in the same cycle
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          oc_fault[ch] <= 1'b0;
        end else if (severe_oc_i[ch] && oc_count == OC_LAST) begin
          oc_fault[ch] <= 1'b1;
        end else if (wr_fault && reg_wdata_i[ch]) begin
          oc_fault[ch] <= 1'b0;
        end
      end

      // Dc offset counted only while the channel plays
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          dc_count <= '0;
        end else if (!dc_offset_i[ch] || ch_hiz_o[ch]) begin
          dc_count <= '0;
        // Stops at the duration, so a shorter one written later acts at once
        end else if (pwm_tick && dc_count < dc_time) begin
          dc_count <= dc_count + 1'b1;
        end
      end

      // Dc trigger record, set wins over clear
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          dc_fault[ch] <= 1'b0;
        end else if (dc_offset_i[ch] && !ch_hiz_o[ch]
                     && dc_count >= dc_time) begin
          dc_fault[ch] <= 1'b1;
        end else if (wr_fault && reg_wdata_i[NUM_CH + ch]) begin
          dc_fault[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // Supply and thermal records hold while the condition is live
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      supply_fault <= '0;
    end else begin
      // Clear only takes once the condition has gone
      supply_fault <= supply_now
                    | (supply_fault
                       & ~({5{wr_supply}} & reg_wdata_i[4:0]));
    end
  end

  assign any_fault = |oc_fault || |dc_stop || |supply_fault;

  // Fault pin, active low open drain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fault_pin_out_o <= 1'b0;
      fault_pin_oe_n_o <= 1'b1;
    end else begin
      fault_pin_out_o <= 1'b0;
      fault_pin_oe_n_o <= !(any_fault || |supply_now);
    end
  end

  // Live conditions bypass the records so outputs float at once
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ch_hiz_o <= '1;
    end else begin
      ch_hiz_o <= ~play | oc_fault | dc_stop
                | {NUM_CH{|supply_now || |supply_fault}};
    end
  end

  // Pulse termination never stops the channel
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pulse_cut_o <= '0;
    end else begin
      pulse_cut_o <= avg_limit_i | peak_limit_i;
    end
  end

  // Foldback steps gain down one notch per warning level
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gain_fold_o <= '0;
    end else begin
      gain_fold_o <= 2'(overtemp_warning_i[0])
                   + 2'(overtemp_warning_i[1])
                   + 2'(overtemp_warning_i[2]);
    end
  end

  // Tweeter detection on channels under test that play
  assign tw_hit = |(tweeter_current_i & tweeter_en & play);

  // Low while over threshold, and at least a switching period
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tw_hold <= '0;
      tw_low <= 1'b0;
    end else if (tw_hit && !tw_low) begin
      tw_low <= 1'b1;
      tw_hold <= PW_LAST;
    end else if (tw_hold != '0) begin
      tw_hold <= tw_hold - 1'b1;
    end else begin
      tw_low <= tw_hit;
    end
  end

  // Shared clip and warning pin, active low open drain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      clip_warn_pin_out_o <= 1'b0;
      clip_warn_pin_oe_n_o <= 1'b1;
    end else begin
      clip_warn_pin_out_o <= 1'b0;
      case (cw_mode)
        APF_CW_CLIP: clip_warn_pin_oe_n_o <= !(|full_duty_i);
        APF_CW_WARN: clip_warn_pin_oe_n_o <= !overtemp_warning_i[0];
        APF_CW_BOTH: clip_warn_pin_oe_n_o <=
          !(|full_duty_i || overtemp_warning_i[0]);
        APF_CW_TWEETER: clip_warn_pin_oe_n_o <= !tw_low;
        default: clip_warn_pin_oe_n_o <= 1'b1;
      endcase
    end
  end

  // Control port floats during power-on reset
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      port_hiz_o <= 1'b1;
    end else begin
      port_hiz_o <= por_i;
    end
  end

  // Read data registered one cycle after the address
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else begin
      case (reg_addr_i)
        FAULT_STATUS_ADDR: reg_rdata_o <= {dc_fault, oc_fault};
        SUPPLY_STATUS_ADDR: reg_rdata_o <= {3'h0, supply_fault};
        THERMAL_WARNING_STATUS_ADDR:
          reg_rdata_o <= {overtemp_warning_i, 5'h00};
        DC_CONTROL_ADDR: reg_rdata_o <= dc_control;
        WARN_PIN_FUNCTION_SELECT_ADDR: reg_rdata_o <= {6'h00, cw_mode};
        CHANNEL_PLAY_CONTROL_ADDR: reg_rdata_o <= {4'h0, play};
        TWEETER_CONTROL_ADDR: reg_rdata_o <= {4'h0, tweeter_en};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule : apf_monitor

/* File: verification/apf_prot_monitor.sv */
`timescale 1ns/1ps
// Pin-level checks of the protection block
module apf_prot_chk #(
  parameter int OC_STOP_DELAY = apf_pkg::OC_STOP_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [apf_pkg::NUM_CH-1:0] avg_limit_i,
  input wire logic [apf_pkg::NUM_CH-1:0] peak_limit_i,
  input wire logic [apf_pkg::NUM_CH-1:0] severe_oc_i,
  input wire logic [2:0] overtemp_warning_i,
  input wire logic thermal_shutdown_i,
  input wire logic low_power_stage_i,
  input wire logic low_analog_i,
  input wire logic low_charge_pump_i,
  input wire logic high_supply_detect_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic port_hiz_o,
  input wire logic [apf_pkg::NUM_CH-1:0] ch_hiz_o,
  input wire logic [apf_pkg::NUM_CH-1:0] pulse_cut_o,
  input wire logic [1:0] gain_fold_o,
  input wire logic fault_pin_oe_n_o
);
  import apf_pkg::*;
  int oc_run; // Edges channel 0 short has lasted
  // Saturates so a long short is seen once only
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      oc_run <= 0;
    end else if (!severe_oc_i[0]) begin
      oc_run <= 0;
    end else if (oc_run < OC_STOP_DELAY + 8) begin
      oc_run <= oc_run + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Registered fault reaction: all channels off, fault pin low
  sequence s_stop_all;
    ##[1:2] (ch_hiz_o == 4'hf && !fault_pin_oe_n_o);
  endsequence
  a_oc_stop: assert property (
    oc_run == OC_STOP_DELAY + 3 |-> ch_hiz_o[0] && !fault_pin_oe_n_o)
    else $error("short channel not stopped");
  a_port_float: assert property (por_i |=> port_hiz_o)
    else $error("port not floated on power-on reset");
  a_cut_follow: assert property (
    1'b1 |=> pulse_cut_o == $past(avg_limit_i | peak_limit_i))
    else $error("pulse cut does not follow limits");
  a_fold_levels: assert property (
    1'b1 |=> gain_fold_o == $countones($past(overtemp_warning_i)))
    else $error("foldback step wrong");
  a_warn_read: assert property (
    reg_addr_i == THERMAL_WARNING_STATUS_ADDR
    && $stable(overtemp_warning_i)
    |=> reg_rdata_o[7:5] == $past(overtemp_warning_i))
    else $error("warning bits wrong");
  a_undervolt_stop: assert property (
    low_power_stage_i || low_analog_i || low_charge_pump_i |-> s_stop_all)
    else $error("undervoltage not handled");
  a_high_supply_stop: assert property (
    high_supply_detect_i |-> s_stop_all)
    else $error("overvoltage not handled");
  a_tsd_stop: assert property (thermal_shutdown_i |-> s_stop_all)
    else $error("thermal shutdown not handled");
endmodule : apf_prot_chk
bind apf_monitor apf_prot_chk #(.OC_STOP_DELAY(OC_STOP_DELAY)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i), .reg_addr_i(reg_addr_i),
  .avg_limit_i(avg_limit_i), .peak_limit_i(peak_limit_i),
  .severe_oc_i(severe_oc_i), .overtemp_warning_i(overtemp_warning_i),
  .thermal_shutdown_i(thermal_shutdown_i), .low_analog_i(low_analog_i),
  .low_power_stage_i(low_power_stage_i),
  .low_charge_pump_i(low_charge_pump_i),
  .high_supply_detect_i(high_supply_detect_i), .reg_rdata_o(reg_rdata_o),
  .port_hiz_o(port_hiz_o), .ch_hiz_o(ch_hiz_o), .pulse_cut_o(pulse_cut_o),
  .gain_fold_o(gain_fold_o), .fault_pin_oe_n_o(fault_pin_oe_n_o));

/* File: verification/apf_host_model.sv */
`timescale 1ns/1ps
// Controller side: register port driver and pulled-up status pins
module apf_host_model (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic fault_pin_oe_n_i,
  input wire logic clip_warn_pin_oe_n_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic fault_level_o,
  output logic clip_warn_level_o
);
  // Released open-drain pins float up to the pull-up level
  assign fault_level_o = fault_pin_oe_n_i ? 1'b1 : 1'b0;
  assign clip_warn_level_o = clip_warn_pin_oe_n_i ? 1'b1 : 1'b0;
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
  end
  // One-cycle strobe; data inverted once unqualified
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : wr
  // Read data lands one cycle after the address is taken
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    @(posedge clk_i);
    #1 d = reg_rdata_i;
  endtask : rd
endmodule : apf_host_model

/* File: verification/amp_protection_fault_monitor_tb_top.sv */
`timescale 1ns/1ps
module amp_protection_fault_monitor_tb_top;
  import apf_pkg::*;
  localparam int OCD = 20; // Shortened overcurrent count
  localparam int PWD = 8; // Shortened switching period
  logic clk_i, reset_i, por_i, wr, port_hiz, fo, fe, co, ce, fl, cl;
  logic [7:0] addr, wdata, rdata, d;
  logic [3:0] avg, peak, sev, dc, full, tw, ch_hiz, cut;
  logic [2:0] overtemp_warning;
  logic [1:0] fold;
  logic [4:0] sup; // Supply conditions in status bit order
  int error_cnt = 0;
  int checks = 0;
  int n;
  typedef struct packed {
    logic [1:0] mode; logic [3:0] avg; logic [3:0] peak; logic [2:0] overtemp_warning;
    logic [3:0] full; logic [3:0] cut; logic [1:0] fold; logic cw;
  } apf_row_s;
  // Pin mode, limits, warnings, full duty -> cut, fold, pin level
  apf_row_s rows [7] = '{'{2'h1, 4'h0, 4'h0, 3'h1, 4'h0, 4'h0, 2'h1, 1'b0},
    '{2'h1, 4'h0, 4'h0, 3'h0, 4'hf, 4'h0, 2'h0, 1'b1},
    '{2'h0, 4'h1, 4'h0, 3'h0, 4'h4, 4'h1, 2'h0, 1'b0},
    '{2'h0, 4'h0, 4'h0, 3'h7, 4'h0, 4'h0, 2'h3, 1'b1},
    '{2'h2, 4'h0, 4'h8, 3'h3, 4'h0, 4'h8, 2'h2, 1'b0},
    '{2'h2, 4'h0, 4'h0, 3'h0, 4'h1, 4'h0, 2'h0, 1'b0},
    '{2'h2, 4'h0, 4'h0, 3'h0, 4'h0, 4'h0, 2'h0, 1'b1}};
  apf_monitor #(.OC_STOP_DELAY(OCD), .PWM_DIV(PWD)) dut (.clk_i(clk_i),
    .reset_i(reset_i), .por_i(por_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .avg_limit_i(avg),
    .peak_limit_i(peak), .severe_oc_i(sev), .dc_offset_i(dc),
    .full_duty_i(full), .tweeter_current_i(tw), .overtemp_warning_i(overtemp_warning),
    .thermal_shutdown_i(sup[4]), .low_power_stage_i(sup[0]),
    .low_analog_i(sup[1]), .low_charge_pump_i(sup[2]),
    .high_supply_detect_i(sup[3]), .reg_rdata_o(rdata),
    .port_hiz_o(port_hiz), .ch_hiz_o(ch_hiz), .pulse_cut_o(cut),
    .gain_fold_o(fold), .fault_pin_out_o(fo), .fault_pin_oe_n_o(fe),
    .clip_warn_pin_out_o(co), .clip_warn_pin_oe_n_o(ce));
  apf_host_model host (.clk_i(clk_i), .reg_rdata_i(rdata),
    .fault_pin_oe_n_i(fe), .clip_warn_pin_oe_n_i(ce), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_wr_o(wr), .fault_level_o(fl),
    .clip_warn_level_o(cl));
  task automatic check(input string nm, input logic [31:0] s,
    input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic tick(input int k); // Let k edges pass, then settle
    repeat (k) @(posedge clk_i);
    #1;
  endtask : tick
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    {reset_i, por_i, avg, peak, sev, dc, full, tw, overtemp_warning, sup} = '0;
    reset_i = 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    host.rd(WARN_PIN_FUNCTION_SELECT_ADDR, d);
    check("mode_reset", d, 8'h01);
    host.rd(8'h01, d);
    check("unmapped", d, 8'h00);
    check("stopped", ch_hiz, 4'hf);
    @(posedge clk_i) overtemp_warning <= 3'h5;
    host.rd(THERMAL_WARNING_STATUS_ADDR, d);
    check("warn_bits", d[7:5], 3'h5);
    host.wr(CHANNEL_PLAY_CONTROL_ADDR, 8'h0f);
    tick(1);
    check("play", ch_hiz, 4'h0);
    foreach (rows[i]) begin
      host.wr(WARN_PIN_FUNCTION_SELECT_ADDR, {6'h00, rows[i].mode});
      @(posedge clk_i);
      {avg, peak, overtemp_warning, full} <= {rows[i].avg, rows[i].peak, rows[i].overtemp_warning,
        rows[i].full};
      tick(3);
      check("cut", cut, rows[i].cut);
      check("fold", fold, rows[i].fold);
      check("clip_warn", cl, rows[i].cw);
      check("playing", ch_hiz, 4'h0);
      check("od_drive", {fo, co}, 2'h0);
    end
    // A dropout restarts the short count
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i) sev <= 4'h1;
      repeat (OCD - 3) @(posedge clk_i);
      sev <= 4'h0;
    end
    tick(3);
    check("no_oc", fl, 1'b1);
    // Channel 0, so the checker's short counter sees it too
    @(posedge clk_i) sev <= 4'h1;
    repeat (OCD + 4) @(posedge clk_i);
    sev <= 4'h0;
    tick(OCD);
    check("oc_only", ch_hiz, 4'h1);
    check("oc_fault", fl, 1'b0);
    host.rd(FAULT_STATUS_ADDR, d);
    check("oc_rec", d, 8'h01);
    host.wr(FAULT_STATUS_ADDR, 8'h01);
    tick(2);
    check("oc_clear", {ch_hiz, fl}, 5'h01);
    @(posedge clk_i) dc <= 4'h8;
    tick(20 * PWD);
    check("dc_quiet", {ch_hiz, fl}, 5'h01);
    host.rd(FAULT_STATUS_ADDR, d);
    check("dc_rec", d, 8'h80);
    host.wr(DC_CONTROL_ADDR, 8'h05);
    tick(4 * PWD);
    check("dc_stop", {ch_hiz, fl}, 5'h10);
    @(posedge clk_i) dc <= 4'h0;
    host.wr(FAULT_STATUS_ADDR, 8'hf0);
    tick(2);
    check("dc_clear", {ch_hiz, fl}, 5'h01);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i) sup <= 5'h01 << i;
      tick(3);
      check("sup_stop", {ch_hiz, fl}, 5'h1e);
      host.rd(SUPPLY_STATUS_ADDR, d);
      check("sup_bit", d[i], 1'b1);
      @(posedge clk_i) sup <= 5'h00;
      host.wr(SUPPLY_STATUS_ADDR, 8'h01 << i);
      tick(2);
      check("sup_clear", {ch_hiz, fl}, 5'h01);
    end
    host.wr(TWEETER_CONTROL_ADDR, 8'h01);
    host.wr(CHANNEL_PLAY_CONTROL_ADDR, 8'h0f);
    host.wr(WARN_PIN_FUNCTION_SELECT_ADDR, 8'h03);
    @(posedge clk_i) tw <= 4'h1;
    @(posedge clk_i) tw <= 4'h0;
    n = 0;
    for (int k = 0; k < 4 * PWD; k++) begin
      tick(1);
      if (cl === 1'b0) n++;
    end
    check("tw_min", n >= PWD, 1'b1);
    check("tw_max", n <= PWD + 2, 1'b1);
    @(posedge clk_i) tw <= 4'h1;
    tick(3 * PWD);
    check("tw_hold", cl, 1'b0);
    @(posedge clk_i) tw <= 4'h0;
    tick(PWD + 3);
    check("tw_free", cl, 1'b1);
    @(posedge clk_i) por_i <= 1'b1;
    tick(2);
    check("por_float", port_hiz, 1'b1);
    @(posedge clk_i) por_i <= 1'b0;
    host.rd(CHANNEL_PLAY_CONTROL_ADDR, d);
    check("por_wipe", d, PLAY_RESET);
    host.wr(CHANNEL_PLAY_CONTROL_ADDR, 8'h0f);
    tick(2);
    check("reinit", {ch_hiz, port_hiz}, 5'h00);
    // Reset again mid-run; pin function must fall back to warning
    host.wr(WARN_PIN_FUNCTION_SELECT_ADDR, 8'h00);
    @(posedge clk_i) reset_i <= 1'b1;
    tick(1);
    check("reset_again", {ch_hiz, port_hiz, fl, rdata}, 14'h3f00);
    @(posedge clk_i) reset_i <= 1'b0;
    host.rd(WARN_PIN_FUNCTION_SELECT_ADDR, d);
    check("mode_again", d, 8'h01);
    print_verdict();
  end
endmodule : amp_protection_fault_monitor_tb_top
